// >>> logic/ssf_status_bank.v
// second status register of the two-port switch with ahb-lite access
// Operation
// - status at index 0x09, resets to zero
// - port 2 tx crc mismatch sets bit 24
// - port 2 short gap drops frame, bit 23
// - port 1 short gap drops frame, bit 8
// - stamp slots a/b/c set bits 20-22
// - bit 19 mirrors port 2 phy interrupt
// - bit 18 urgent frame waiting, generic only
// - store-forward: bit 17 when frame held
// - cut-through: bit 17 on level or eof
// - high priority first unless config reverses
// - tx ecc error flushes tx fifo, bit 12
// - rx ecc error clears rx fifo, bit 11
// - generic spi crc error sets bit 10
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssf_defs.vh"

module ssf_status_bank #(
  parameter GAP_W      = 16,
  parameter LEVEL_W    = 12,
  parameter CNT_W      = 8,
  parameter GAP_P1_RST = 16'h000c,
  parameter GAP_P2_RST = 16'h000c,
  parameter LEVEL_RST  = 12'h040
) (
  // clock and reset
  input  wire               core_clk,
  input  wire               rst,
  // ahb-lite slave
  input  wire               hsel,
  input  wire [31:0]        haddr,
  input  wire [1:0]         htrans,
  input  wire               hwrite,
  input  wire [2:0]         hsize,
  input  wire [31:0]        hwdata,
  input  wire               hready,
  output wire               hreadyout,
  output wire               hresp,
  output reg  [31:0]        hrdata,
  // receive activity for gap checking
  input  wire               firstPortFrameActive,
  input  wire               secondPortFrameActive,
  output wire               firstPortFrameDrop,
  output wire               secondPortFrameDrop,
  // port 2 transmit events
  input  wire               secondPortTxCrcMismatch,
  input  wire [2:0]         secondPortStampSlotLoad,
  // port 2 phy interrupt pin
  input  wire               secondPortPhyIrqPin,
  // port 2 receive fifo state
  input  wire [CNT_W-1:0]   secondPortHiFrames,
  input  wire [CNT_W-1:0]   secondPortLoFrames,
  input  wire [LEVEL_W-1:0] secondPortRxLevel,
  input  wire               secondPortEofHeld,
  output reg                secondPortServeHigh,
  // fifo integrity and serial host errors
  input  wire               txSizeEccError,
  input  wire               rxSizeEccError,
  input  wire               hostCrcError,
  output reg                txFifoFlush,
  output reg                rxFifoFlush
);

  // ---------------------------------------------------------------
  // ahb address phase capture
  // ---------------------------------------------------------------
  reg                   wrPend_ff;
  reg  [`SSF_IDX_W-1:0] wrIdx_ff;
  wire                  addrValid;
  wire                  rdReq;
  wire [`SSF_IDX_W-1:0] reqIdx;

  // zero-wait slave: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = `SSF_HRESP_OKAY;
  assign addrValid = hsel & hready & (htrans == `SSF_HTRANS_NONSEQ || htrans == `SSF_HTRANS_SEQ);
  assign rdReq     = addrValid & ~hwrite;
  assign reqIdx    = haddr[`SSF_IDX_W+1:2];

  // writes land one cycle later, when hwdata is on the bus
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrIdx_ff  <= {`SSF_IDX_W{1'b0}};
    end else begin
      wrPend_ff <= addrValid & hwrite & (hsize == `SSF_HSIZE_WORD);
      wrIdx_ff  <= reqIdx;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg  [2:0]         cfg_ff;
  reg  [LEVEL_W-1:0] receiveCutThroughLevel_ff;
  reg  [GAP_W-1:0]   firstPortGapThreshold_ff;
  reg  [GAP_W-1:0]   secondPortGapThreshold_ff;
  wire               cutThrough;
  wire               serveLowPriorityFirst;
  wire               chunkProtocol;

  assign cutThrough            = cfg_ff[`SSF_C_CUT_THROUGH];
  assign serveLowPriorityFirst = cfg_ff[`SSF_C_LOW_FIRST];
  assign chunkProtocol         = cfg_ff[`SSF_C_CHUNK_PROTO];

  // software-owned steering of mode, order, level and gaps
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff                    <= `SSF_CFG_RST;
      receiveCutThroughLevel_ff <= LEVEL_RST;
      firstPortGapThreshold_ff  <= GAP_P1_RST;
      secondPortGapThreshold_ff <= GAP_P2_RST;
    end else if (wrPend_ff) begin
      case (wrIdx_ff)
        `SSF_IDX_CFG: begin
          cfg_ff <= hwdata[2:0];
        end
        `SSF_IDX_LEVEL: begin
          receiveCutThroughLevel_ff <= hwdata[LEVEL_W-1:0];
        end
        `SSF_IDX_GAP: begin
          firstPortGapThreshold_ff  <= hwdata[`SSF_GAP_P1_LSB+GAP_W-1:`SSF_GAP_P1_LSB];
          secondPortGapThreshold_ff <= hwdata[`SSF_GAP_P2_LSB+GAP_W-1:`SSF_GAP_P2_LSB];
        end
        default: begin
          cfg_ff <= cfg_ff;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interframe gap checkers, one per port
  // ---------------------------------------------------------------
  wire firstPortGapEvt;
  wire secondPortGapEvt;

  ssf_gap_checker #(
    .GAP_W(GAP_W)
  ) u_gap_first (
    .core_clk     (core_clk),
    .rst          (rst),
    .frameActive  (firstPortFrameActive),
    .gapThreshold (firstPortGapThreshold_ff),
    .frameDrop_ff (firstPortFrameDrop),
    .dropPulse_ff (firstPortGapEvt)
  );

  ssf_gap_checker #(
    .GAP_W(GAP_W)
  ) u_gap_second (
    .core_clk     (core_clk),
    .rst          (rst),
    .frameActive  (secondPortFrameActive),
    .gapThreshold (secondPortGapThreshold_ff),
    .frameDrop_ff (secondPortFrameDrop),
    .dropPulse_ff (secondPortGapEvt)
  );

  // ---------------------------------------------------------------
  // phy interrupt pin synchroniser
  // ---------------------------------------------------------------
  reg phyIrqMeta_ff;
  reg phyIrqSync_ff;

  // pin is asynchronous; only the second stage is read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phyIrqMeta_ff <= 1'b0;
      phyIrqSync_ff <= 1'b0;
    end else begin
      phyIrqMeta_ff <= secondPortPhyIrqPin;
      phyIrqSync_ff <= phyIrqMeta_ff;
    end
  end

  // ---------------------------------------------------------------
  // receive readiness and priority choice for port 2
  // ---------------------------------------------------------------
  wire hiHeld;
  wire loHeld;
  reg  rxAvail_ff;
  reg  urgent_ff;

  assign hiHeld = (secondPortHiFrames != {CNT_W{1'b0}});
  assign loHeld = (secondPortLoFrames != {CNT_W{1'b0}});

  // readiness bits only carry meaning under the generic protocol
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxAvail_ff          <= 1'b0;
      urgent_ff           <= 1'b0;
      secondPortServeHigh <= 1'b1;
    end else begin
      if (chunkProtocol) begin
        rxAvail_ff <= 1'b0;
      end else if (cutThrough) begin
        rxAvail_ff <= (secondPortRxLevel >= receiveCutThroughLevel_ff) | secondPortEofHeld;
      end else begin
        rxAvail_ff <= hiHeld | loHeld;
      end
      urgent_ff <= hiHeld & ~chunkProtocol;
      // with both queues loaded the config bit picks the order
      if (hiHeld & loHeld) begin
        secondPortServeHigh <= ~serveLowPriorityFirst;
      end else begin
        secondPortServeHigh <= hiHeld;
      end
    end
  end

  // ---------------------------------------------------------------
  // fifo flush strobes on uncorrectable size-field errors
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txFifoFlush <= 1'b0;
      rxFifoFlush <= 1'b0;
    end else begin
      txFifoFlush <= txSizeEccError;
      rxFifoFlush <= rxSizeEccError;
    end
  end

  // ---------------------------------------------------------------
  // sticky write-one-to-clear flags
  // ---------------------------------------------------------------
  reg  [31:0] flags_ff;
  reg  [31:0] nxt_flags;
  reg  [31:0] setVec;
  wire [31:0] clrVec;
  wire [31:0] stickyMask;
  wire [31:0] statusRead;

  assign stickyMask = (32'h1 << `SSF_B_P2_CRC) | (32'h1 << `SSF_B_P2_GAP)
                    | (32'h1 << `SSF_B_SLOT_C) | (32'h1 << `SSF_B_SLOT_B)
                    | (32'h1 << `SSF_B_SLOT_A) | (32'h1 << `SSF_B_TX_ECC)
                    | (32'h1 << `SSF_B_RX_ECC) | (32'h1 << `SSF_B_SPI_CRC)
                    | (32'h1 << `SSF_B_P1_GAP);
  assign clrVec = (wrPend_ff && wrIdx_ff == `SSF_IDX_STATUS) ? hwdata : 32'h0;

  // event vector gathered into bit positions
  always @* begin
    setVec                 = 32'h0;
    setVec[`SSF_B_P2_CRC]  = secondPortTxCrcMismatch;
    setVec[`SSF_B_P2_GAP]  = secondPortGapEvt;
    setVec[`SSF_B_SLOT_C]  = secondPortStampSlotLoad[2];
    setVec[`SSF_B_SLOT_B]  = secondPortStampSlotLoad[1];
    setVec[`SSF_B_SLOT_A]  = secondPortStampSlotLoad[0];
    setVec[`SSF_B_TX_ECC]  = txSizeEccError;
    setVec[`SSF_B_RX_ECC]  = rxSizeEccError;
    setVec[`SSF_B_SPI_CRC] = hostCrcError & ~chunkProtocol;
    setVec[`SSF_B_P1_GAP]  = firstPortGapEvt;
  end

  // set wins over a clear in the same cycle; zeros written keep the flag
  always @* begin
    nxt_flags = ((flags_ff & ~clrVec) | setVec) & stickyMask;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= `SSF_STATUS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // level bits are live; reserved bits read as zero
  assign statusRead = flags_ff
                    | ({31'h0, phyIrqSync_ff} << `SSF_B_PHY_IRQ)
                    | ({31'h0, urgent_ff} << `SSF_B_URGENT)
                    | ({31'h0, rxAvail_ff} << `SSF_B_RX_AVAIL);

  // ---------------------------------------------------------------
  // read data, registered at the address phase edge
  // ---------------------------------------------------------------
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h0;
    case (reqIdx)
      `SSF_IDX_STATUS: begin
        nxt_rdata = statusRead;
      end
      `SSF_IDX_CFG: begin
        nxt_rdata = {29'h0, cfg_ff};
      end
      `SSF_IDX_LEVEL: begin
        nxt_rdata[LEVEL_W-1:0] = receiveCutThroughLevel_ff;
      end
      `SSF_IDX_GAP: begin
        nxt_rdata[`SSF_GAP_P1_LSB+GAP_W-1:`SSF_GAP_P1_LSB] = firstPortGapThreshold_ff;
        nxt_rdata[`SSF_GAP_P2_LSB+GAP_W-1:`SSF_GAP_P2_LSB] = secondPortGapThreshold_ff;
      end
      default: begin
        nxt_rdata = 32'h0;
      end
    endcase
  end

  // unmapped indices answer zero with an okay response
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (rdReq) begin
      hrdata <= nxt_rdata;
    end
  end

endmodule // ssf_status_bank

`default_nettype wire

// >>> logic/ssf_defs.vh
// register map, field positions and reset values of the switch status flag bank
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// register indices; byte address is four times the index
`define SSF_IDX_STATUS      6'h09
`define SSF_IDX_CFG         6'h10
`define SSF_IDX_LEVEL       6'h11
`define SSF_IDX_GAP         6'h12
`define SSF_IDX_W           6

// status register reset value
`define SSF_STATUS_RST      32'h00000000

// status bit positions
`define SSF_B_P2_CRC        24
`define SSF_B_P2_GAP        23
`define SSF_B_SLOT_C        22
`define SSF_B_SLOT_B        21
`define SSF_B_SLOT_A        20
`define SSF_B_PHY_IRQ       19
`define SSF_B_URGENT        18
`define SSF_B_RX_AVAIL      17
`define SSF_B_TX_ECC        12
`define SSF_B_RX_ECC        11
`define SSF_B_SPI_CRC       10
`define SSF_B_P1_GAP        8

// configuration bit positions
`define SSF_C_CUT_THROUGH   0
`define SSF_C_LOW_FIRST     1
`define SSF_C_CHUNK_PROTO   2
`define SSF_CFG_RST         3'h0

// field positions of the gap threshold register
`define SSF_GAP_P1_LSB      0
`define SSF_GAP_P2_LSB      16

// ahb transfer type and size codes
`define SSF_HTRANS_NONSEQ   2'h2
`define SSF_HTRANS_SEQ      2'h3
`define SSF_HSIZE_WORD      3'h2
`define SSF_HRESP_OKAY      1'b0

`endif

// >>> logic/ssf_gap_checker.v
// interframe gap checker: flags and drops frames that follow too short a gap
`timescale 1ns/1ns
`default_nettype none

module ssf_gap_checker #(
  parameter GAP_W = 16
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // receive frame activity
  input  wire             frameActive,
  input  wire [GAP_W-1:0] gapThreshold,
  // results
  output reg              frameDrop_ff,
  output reg              dropPulse_ff
);

  reg  [GAP_W-1:0] gapCnt_ff;
  reg              activeDly_ff;
  reg              seenFrame_ff;
  wire             frameStart;
  wire             gapShort;

  assign frameStart = frameActive & ~activeDly_ff;
  // first frame after reset has no gap to judge
  assign gapShort   = seenFrame_ff & (gapCnt_ff < gapThreshold);

  // idle counter saturates so very long gaps never wrap into short ones
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gapCnt_ff    <= {GAP_W{1'b0}};
      activeDly_ff <= 1'b0;
      seenFrame_ff <= 1'b0;
      frameDrop_ff <= 1'b0;
      dropPulse_ff <= 1'b0;
    end else begin
      activeDly_ff <= frameActive;
      dropPulse_ff <= frameStart & gapShort;
      if (frameActive) begin
        gapCnt_ff    <= {GAP_W{1'b0}};
        seenFrame_ff <= 1'b1;
      end else if (gapCnt_ff != {GAP_W{1'b1}}) begin
        gapCnt_ff <= gapCnt_ff + {{(GAP_W-1){1'b0}}, 1'b1};
      end
      // drop holds for the whole frame once it starts short
      if (frameStart) begin
        frameDrop_ff <= gapShort;
      end else if (!frameActive) begin
        frameDrop_ff <= 1'b0;
      end
    end
  end

endmodule // ssf_gap_checker

`default_nettype wire

// >>> tb/ssf_status_bank_assertions.sv
// port-level assertions for the switch status flag bank
`timescale 1ns/1ns
`default_nettype none
`include "ssf_defs.vh"

module ssf_status_bank_assertions #(
  parameter CNT_W = 8
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rst,
  // ahb-lite side
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  // events and levels
  input wire logic             firstPortFrameActive,
  input wire logic             firstPortFrameDrop,
  input wire logic             secondPortTxCrcMismatch,
  input wire logic             secondPortPhyIrqPin,
  input wire logic [CNT_W-1:0] secondPortHiFrames,
  input wire logic [CNT_W-1:0] secondPortLoFrames,
  input wire logic             secondPortServeHigh,
  input wire logic             txSizeEccError,
  input wire logic             txFifoFlush,
  input wire logic             rxSizeEccError,
  input wire logic             rxFifoFlush
);
  // read address phases, any register and the status word
  wire rdAny    = hsel && hready && htrans[1] && !hwrite;
  wire rdStatus = rdAny && (haddr == 32'h00000024);
  // a status write taken with the event would clear the flag before a later read
  wire wrStatus = hsel && hready && htrans[1] && hwrite && (haddr == 32'h00000024);

  a_bus_zero_wait: assert property (@(posedge core_clk) disable iff (rst) hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (rst) !rdAny |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    rdStatus |=> (hrdata & 32'hfe01e2ff) == 32'h0) else $error("reserved status bits not zero");
  a_crc_flag_seen: assert property (@(posedge core_clk) disable iff (rst)
    (secondPortTxCrcMismatch && !wrStatus) ##[1:2] rdStatus |=> hrdata[24]) else $error("crc flag missing");
  a_phy_mirrors: assert property (@(posedge core_clk) disable iff (rst)
    secondPortPhyIrqPin [*5] ##0 rdStatus |=> hrdata[19]) else $error("phy bit not mirrored");
  a_serve_high_only: assert property (@(posedge core_clk) disable iff (rst)
    (secondPortHiFrames != 0 && secondPortLoFrames == 0) |=> secondPortServeHigh) else $error("high not served");
  a_serve_low_only: assert property (@(posedge core_clk) disable iff (rst)
    (secondPortHiFrames == 0 && secondPortLoFrames != 0) |=> !secondPortServeHigh) else $error("low not served");
  a_tx_flush_follows: assert property (@(posedge core_clk) disable iff (rst)
    txSizeEccError |=> txFifoFlush) else $error("tx flush missing");
  a_rx_flush_cause: assert property (@(posedge core_clk) disable iff (rst)
    rxFifoFlush |-> $past(rxSizeEccError)) else $error("rx flush without cause");
  a_drop_at_start: assert property (@(posedge core_clk) disable iff (rst)
    $rose(firstPortFrameDrop) |-> $past(firstPortFrameActive) && !$past(firstPortFrameActive, 2))
    else $error("drop not at frame start");
  a_drop_ends: assert property (@(posedge core_clk) disable iff (rst)
    firstPortFrameDrop && !firstPortFrameActive |=> !firstPortFrameDrop) else $error("drop outlives frame");
endmodule // ssf_status_bank_assertions

bind ssf_status_bank ssf_status_bank_assertions #(.CNT_W(CNT_W)) i_ssf_status_bank_assertions (
  .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .firstPortFrameActive, .firstPortFrameDrop, .secondPortTxCrcMismatch, .secondPortPhyIrqPin,
  .secondPortHiFrames, .secondPortLoFrames, .secondPortServeHigh, .txSizeEccError, .txFifoFlush,
  .rxSizeEccError, .rxFifoFlush);

`default_nettype wire

// >>> tb/test_switch_status_flags_bank.sv
// self-checking testbench of the switch status flag bank
`timescale 1ns/1ns
`default_nettype none
`include "ssf_defs.vh"

module test_switch_status_flags_bank;
  logic        core_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, act = 0;
  logic [2:0]  hsize = 0, secondPortStampSlotLoad;
  logic [6:0]  ev = 0;
  logic [7:0]  secondPortHiFrames = 0, secondPortLoFrames = 0;
  logic [11:0] secondPortRxLevel = 0;
  logic        secondPortPhyIrqPin = 0, secondPortEofHeld = 0, secondPortServeHigh;
  logic        firstPortFrameActive, secondPortFrameActive, firstPortFrameDrop, secondPortFrameDrop;
  logic        secondPortTxCrcMismatch, txSizeEccError, rxSizeEccError, hostCrcError, txFifoFlush, rxFifoFlush;
  int          fails = 0, comparisons = 0, cycles = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  assign {hostCrcError, rxSizeEccError, txSizeEccError, secondPortStampSlotLoad, secondPortTxCrcMismatch} = ev;
  assign {secondPortFrameActive, firstPortFrameActive} = act;

  ssf_status_bank i_ssf_status_bank (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .firstPortFrameActive, .secondPortFrameActive, .firstPortFrameDrop,
    .secondPortFrameDrop, .secondPortTxCrcMismatch, .secondPortStampSlotLoad, .secondPortPhyIrqPin,
    .secondPortHiFrames, .secondPortLoFrames, .secondPortRxLevel, .secondPortEofHeld, .secondPortServeHigh,
    .txSizeEccError, .rxSizeEccError, .hostCrcError, .txFifoFlush, .rxFifoFlush);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // one ahb-lite word transfer; evData is raised through the data phase
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic [6:0] evData = 0);
    @(posedge core_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2; haddr <= {24'h0, idx, 2'h0};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd; ev <= evData;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    ev <= 7'h0;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(what, exp, rd);
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge core_clk); ev <= v;
    @(posedge core_clk); ev <= 7'h0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic testReset;
    rdChk("status reset", `SSF_IDX_STATUS, 32'h0);
    rdChk("unmapped read", 6'h3f, 32'h0);
    $display("test reset done");
  endtask

  // each of the seven ev inputs sets its own bit, zero writes keep it, one writes clear it
  task automatic testEvents;
    int pos [7] = '{24, 20, 21, 22, 12, 11, 10};
    for (int k = 0; k < 7; k++) begin
      pulse(7'h1 << k);
      // flush strobe stands for one cycle after the ecc pulse; look mid-cycle
      @(negedge core_clk);
      check("flush pulse", (k == 4) ? 32'h2 : (k == 5) ? 32'h1 : 32'h0, {30'h0, txFifoFlush, rxFifoFlush});
      rdChk("flag set", `SSF_IDX_STATUS, 32'h1 << pos[k]);
      xfer(1'b1, `SSF_IDX_STATUS, 32'h0);
      rdChk("zero write", `SSF_IDX_STATUS, 32'h1 << pos[k]);
      xfer(1'b1, `SSF_IDX_STATUS, 32'h1 << pos[k]);
      rdChk("flag cleared", `SSF_IDX_STATUS, 32'h0);
    end
    xfer(1'b1, `SSF_IDX_CFG, 32'h4);
    pulse(7'h40);
    rdChk("chunk crc", `SSF_IDX_STATUS, 32'h0);
    xfer(1'b1, `SSF_IDX_CFG, 32'h0);
    // clear and a fresh event on the same edge
    pulse(7'h01);
    xfer(1'b1, `SSF_IDX_STATUS, 32'h01000000, 7'h01);
    rdChk("set beats clear", `SSF_IDX_STATUS, 32'h01000000);
    xfer(1'b1, `SSF_IDX_STATUS, 32'h01000000);
    $display("test events done");
  endtask

  task automatic testPhy;
    secondPortPhyIrqPin <= 1'b1;
    waitc(6);
    rdChk("phy high", `SSF_IDX_STATUS, 32'h00080000);
    xfer(1'b1, `SSF_IDX_STATUS, 32'h00080000);
    rdChk("phy read only", `SSF_IDX_STATUS, 32'h00080000);
    secondPortPhyIrqPin <= 1'b0;
    waitc(6);
    rdChk("phy low", `SSF_IDX_STATUS, 32'h0);
    $display("test phy done");
  endtask

  task automatic testRx;
    secondPortLoFrames <= 8'h1;
    waitc(2);
    rdChk("low frame", `SSF_IDX_STATUS, 32'h00020000);
    check("serve low only", 32'h0, {31'h0, secondPortServeHigh});
    secondPortHiFrames <= 8'h1;
    waitc(2);
    rdChk("urgent frame", `SSF_IDX_STATUS, 32'h00060000);
    check("serve both", 32'h1, {31'h0, secondPortServeHigh});
    xfer(1'b1, `SSF_IDX_CFG, 32'h2);
    waitc(2);
    check("serve low first", 32'h0, {31'h0, secondPortServeHigh});
    // only the high queue loaded: host reads the port that flags urgent
    secondPortLoFrames <= 8'h0;
    waitc(2);
    check("serve high only", 32'h1, {31'h0, secondPortServeHigh});
    rdChk("only urgent", `SSF_IDX_STATUS, 32'h00060000);
    xfer(1'b1, `SSF_IDX_CFG, 32'h4);
    rdChk("chunk protocol", `SSF_IDX_STATUS, 32'h0);
    secondPortHiFrames <= 8'h0; secondPortLoFrames <= 8'h0; secondPortRxLevel <= 12'h03f;
    xfer(1'b1, `SSF_IDX_CFG, 32'h1);
    rdChk("below level", `SSF_IDX_STATUS, 32'h0);
    secondPortRxLevel <= 12'h040;
    waitc(2);
    rdChk("level reached", `SSF_IDX_STATUS, 32'h00020000);
    secondPortRxLevel <= 12'h0; secondPortEofHeld <= 1'b1;
    waitc(2);
    rdChk("eof held", `SSF_IDX_STATUS, 32'h00020000);
    secondPortEofHeld <= 1'b0;
    xfer(1'b1, `SSF_IDX_CFG, 32'h0);
    $display("test rx done");
  endtask

  // two frames on both ports split by the given idle cycles
  task automatic frames(input int idle);
    act <= 2'h3; waitc(3);
    act <= 2'h0; waitc(idle);
    act <= 2'h3; waitc(3);
  endtask

  task automatic testGap;
    frames(2);
    check("drop pins", 32'h3, {30'h0, secondPortFrameDrop, firstPortFrameDrop});
    act <= 2'h0; waitc(2);
    rdChk("gap flags", `SSF_IDX_STATUS, 32'h00800100);
    xfer(1'b1, `SSF_IDX_STATUS, 32'h00800100);
    xfer(1'b1, `SSF_IDX_GAP, 32'h00010001);
    frames(2);
    act <= 2'h0; waitc(2);
    rdChk("low threshold", `SSF_IDX_STATUS, 32'h0);
    $display("test gap done");
  endtask

  task automatic give_verdict;
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      give_verdict;
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    testReset;
    testEvents;
    testPhy;
    testRx;
    testGap;
    give_verdict;
  end
endmodule // test_switch_status_flags_bank

`default_nettype wire
